// ---- design/clk_ctrl_pkg.sv ----
// constants, types and decode helpers for the power-mode clock controller
// assumes a 20 MHz core clock; used by the start-up timer and mode controller design files
package clk_ctrl_pkg;
  // timing figures and derived cycle counts
  localparam int CLK_MHZ = 20; // core clock rate in MHz
  localparam int POWERUP_TIMER_US = 64; // power-up timer delay in us
  localparam int CPU_READY_DELAY_US = 2; // cpu-ready delay in us
  localparam int PLL_LOCK_US = 2000; // pll lock wait in us
  localparam int POWERUP_TIMER_CYC = POWERUP_TIMER_US * CLK_MHZ;
  localparam int CPU_READY_DELAY_CYC = CPU_READY_DELAY_US * CLK_MHZ;
  localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
  localparam int OST_TICKS = 1024; // crystal cycles counted before release
  localparam int CNT_W = 16;
  localparam int OST_W = 11;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] CFG_OFS = 4'h4;
  localparam logic [3:0] CMD_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hc;
  // control register fields
  localparam int CTRL_W = 8;
  localparam int IDLE_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int FREQ_LSB = 3;
  localparam int SRC_BIT = 6;
  localparam int MID_BIT = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h18;
  // configuration register fields
  localparam int CFG_W = 9;
  localparam int PRIMARY_OSC_CONFIG_LSB = 0;
  localparam int POWERUP_TIMER_ENABLE_N_N_BIT = 4;
  localparam int FAST_BIT = 5;
  localparam int PLL_BIT = 6;
  localparam int WDT_BIT = 7;
  localparam int TMR_BIT = 8;
  localparam logic [CFG_W-1:0] CFG_RST = 9'h002;
  // command register bits
  localparam int SLEEP_CMD_BIT = 0;
  localparam int RESTART_CMD_BIT = 1;
  // status register fields
  localparam int ST_HF = 0;
  localparam int ST_MF = 1;
  localparam int ST_LF = 2;
  localparam int ST_STARTUP_COMPLETE_FLAG = 3;
  localparam int ST_SEL_OK = 4;
  localparam int ST_HOLD = 5;
  localparam int ST_MODE_LSB = 6;
  // primary oscillator configuration codes
  localparam logic [3:0] LP_XTAL = 4'h0;
  localparam logic [3:0] STD_XTAL = 4'h1;
  localparam logic [3:0] HS_XTAL = 4'h2;
  localparam logic [3:0] EXT_CLK = 4'h3;
  localparam logic [3:0] INT_OSC = 4'h4;
  localparam logic [3:0] RC_OSC = 4'h5;
  // clock select codes
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;

  typedef enum logic [2:0] {M_PRIMARY_RUN_MODE, M_SECONDARY_RUN_MODE, M_INT_RUN, M_PRIMARY_IDLE_MODE, M_SECONDARY_IDLE_MODE, M_INT_IDLE,
                            M_SLEEP, M_WAKE} mode_t;
  typedef enum logic [1:0] {INT_LF, INT_MF, INT_HF} int_osc_t;
  typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL, SRC_NONE} clk_src_t;

  // internal oscillator chosen by frequency field, source bit and mid select
  function automatic int_osc_t int_osc_pick(input logic [2:0] freq, input logic src, input logic mid);
    int_osc_t pick;
    if (freq == 3'h0 && !src) pick = INT_LF;
    else if (freq <= 3'h2) pick = mid ? INT_MF : INT_HF;
    else pick = INT_HF;
    return pick;
  endfunction : int_osc_pick
endpackage : clk_ctrl_pkg

// ---- design/startup_if.sv ----
// signals between the mode controller and the start-up timer
// assumes both ends run on the core clock
`timescale 1ns/1ps
`default_nettype none
interface startup_if;
  logic start_full; // pulse: run all configured power-up delays
  logic start_wake; // pulse: run only the cpu-ready delay
  logic crystal; // crystal mode, count oscillator cycles
  logic pll_on; // pll lock wait after the count
  logic powerup_timer_on; // power-up timer in use
  logic hf_wait; // wait for high-frequency oscillator stable
  logic prim_tick; // one pulse per primary oscillator cycle
  logic hf_ready; // high-frequency oscillator stable
  logic busy; // some delay still running
  modport seq (input start_full, start_wake, crystal, pll_on, powerup_timer_on, hf_wait, prim_tick, hf_ready,
               output busy);
  modport ctrl (output start_full, start_wake, crystal, pll_on, powerup_timer_on, hf_wait, prim_tick, hf_ready,
                input busy);
endinterface : startup_if
`default_nettype wire

// ---- design/startup_timer.sv ----
// power-up delay timers: power-up, oscillator start-up and cpu-ready side by side, pll lock after the start-up count
// assumes start pulses and synchronised ticks from the mode controller on the same clock
`timescale 1ns/1ps
`default_nettype none
module startup_timer #(
  parameter int PLL_CYC = clk_ctrl_pkg::PLL_LOCK_CYC // pll lock wait in cycles
) (
  input wire logic core_clk_i, // core clock
  input wire logic rst_b_i, // synchronous reset, active low
  startup_if.seq su // start requests and busy answer
);
  import clk_ctrl_pkg::*;

  logic [CNT_W-1:0] powerup_timer_r;
  logic [CNT_W-1:0] cpu_ready_delay_r;
  logic [CNT_W-1:0] pll_r;
  logic [OST_W-1:0] ost_r;
  logic pll_wait_r;
  logic hf_wait_r;

  // power-up timer, loaded only when enabled by the active-low bit
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) powerup_timer_r <= '0;
    else if (su.start_full) powerup_timer_r <= su.powerup_timer_on ? CNT_W'(POWERUP_TIMER_CYC) : '0;
    else if (powerup_timer_r != '0) powerup_timer_r <= powerup_timer_r - 1'b1;
  end

  // oscillator start-up count on crystal cycles
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) ost_r <= '0;
    else if (su.start_full) ost_r <= su.crystal ? OST_W'(OST_TICKS) : '0;
    else if (ost_r != '0 && su.prim_tick) ost_r <= ost_r - 1'b1;
  end

  // pll lock wait begins once the start-up count has ended
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pll_wait_r <= 1'b0;
      pll_r <= '0;
    end else if (su.start_full) begin
      pll_wait_r <= su.pll_on;
      pll_r <= '0;
    end else if (pll_wait_r && ost_r == '0) begin
      pll_wait_r <= 1'b0;
      pll_r <= CNT_W'(PLL_CYC);
    end else if (pll_r != '0) pll_r <= pll_r - 1'b1;
  end

  // cpu-ready delay, concurrent with the others and rerun on wake
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) cpu_ready_delay_r <= '0;
    else if (su.start_full || su.start_wake) cpu_ready_delay_r <= CNT_W'(CPU_READY_DELAY_CYC);
    else if (cpu_ready_delay_r != '0) cpu_ready_delay_r <= cpu_ready_delay_r - 1'b1;
  end

  // hold until the high-frequency oscillator reports stable
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) hf_wait_r <= 1'b0;
    else if (su.start_full) hf_wait_r <= su.hf_wait;
    else if (su.hf_ready) hf_wait_r <= 1'b0;
  end

  assign su.busy = powerup_timer_r != '0 || ost_r != '0 || pll_r != '0 || cpu_ready_delay_r != '0 || pll_wait_r || hf_wait_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  powerup_timer_load_a: assert property (su.start_full |=> powerup_timer_r == (su.powerup_timer_on ? CNT_W'(POWERUP_TIMER_CYC) : '0))
    else $error("power-up timer load wrong");
  ost_hold_a: assert property (su.start_full && su.crystal |=> su.busy && ost_r == OST_W'(OST_TICKS))
    else $error("start-up count not started");
  cpu_ready_delay_load_a: assert property (su.start_wake && !su.start_full |=> cpu_ready_delay_r == CNT_W'(CPU_READY_DELAY_CYC) ##1 su.busy)
    else $error("cpu-ready delay not loaded");
endmodule : startup_timer
`default_nettype wire

// ---- design/clock_mode_ctrl.sv ----
// power-mode clock control: oscillator enables, clock gating, reset hold and an avalon-mm register slave
// assumes an avalon-mm master on core_clk_i; oscillator ready, clock pin and wake inputs are asynchronous
// Notes on behaviour
// - primary idle keeps primary oscillator running
// - secondary, internal and sleep modes stop the primary oscillator
// - secondary modes clock from secondary oscillator
// - internal modes clock from internal oscillator
// - low-frequency direct clock disables high/mid outputs
// - sleep stops every clock source but a watchdog-held low-frequency oscillator
// - watchdog keeps low-frequency oscillator running
// - power-up timer only when enable bit zero
// - crystal modes wait 1024 oscillator cycles
// - pll adds 2 ms after start-up count
// - cpu-ready delay runs alongside other delays
// - fast-start bit skips high-frequency stable wait
// - frequency field and bits pick internal oscillator
// - stable flag per internal oscillator readable
// - primary idle stops cpu, peripherals keep clock
// - wake runs cpu after cpu-ready delay
// - wake leaves idle and select bits unchanged
`timescale 1ns/1ps
`default_nettype none
module clock_mode_ctrl #(
  parameter int PLL_CYC = clk_ctrl_pkg::PLL_LOCK_CYC // pll lock wait in cycles
) (
  input wire logic core_clk_i, // 20 MHz core clock
  input wire logic rst_b_i, // synchronous power-on reset, active low
  input wire logic [3:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall the master
  input wire logic prim_osc_i, // primary oscillator clock pin
  input wire logic hf_ready_i, // high-frequency oscillator stable
  input wire logic mf_ready_i, // mid-frequency oscillator stable
  input wire logic lf_ready_i, // low-frequency oscillator stable
  input wire logic wake_i, // wake event
  output logic primary_osc_en_o, // primary oscillator enable
  output logic secondary_osc_en_o, // secondary oscillator enable
  output logic hf_osc_en_o, // high-frequency internal enable
  output logic mf_osc_en_o, // mid-frequency internal enable
  output logic lf_osc_en_o, // low-frequency internal enable
  output var clk_ctrl_pkg::clk_src_t sys_clk_src_o, // system clock mux select
  output var clk_ctrl_pkg::int_osc_t int_osc_sel_o, // internal oscillator in use
  output logic [2:0] int_freq_o, // internal postscaler setting
  output logic cpu_clk_en_o, // cpu clock gate
  output logic periph_clk_en_o, // peripheral clock gate
  output logic cpu_rst_b_o, // cpu reset, active low
  output logic periph_rst_b_o // peripheral reset, active low
);
  import clk_ctrl_pkg::*;

  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic prim_d_r;
  logic wake_d_r;
  logic prim_tick;
  logic wake_edge;
  logic wait_r;
  logic req;
  logic commit_wr;
  logic [CTRL_W-1:0] ctrl_r;
  logic [CFG_W-1:0] cfg_r;
  logic started_r;
  logic startup_r;
  logic startup_complete_flag_r;
  logic sleep_go;
  logic restart_go;
  mode_t mode_r;
  logic idle_bit;
  logic [1:0] sel;
  logic [2:0] freq;
  logic [3:0] primary_osc_config;
  int_osc_t isel;
  logic pin_cfg;
  logic prim_side;
  logic sec_side;
  logic int_act;
  logic run_mode;
  logic hold;
  logic [8:0] status;

  startup_if su ();

  startup_timer #(.PLL_CYC(PLL_CYC)) u_timer (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .su(su)
  );

  // run mode for a clock select value
  function automatic mode_t run_of(input logic [1:0] s);
    return s[1] ? M_INT_RUN : (s == SEL_SECONDARY ? M_SECONDARY_RUN_MODE : M_PRIMARY_RUN_MODE);
  endfunction : run_of

  // idle mode for a clock select value
  function automatic mode_t idle_of(input logic [1:0] s);
    return s[1] ? M_INT_IDLE : (s == SEL_SECONDARY ? M_SECONDARY_IDLE_MODE : M_PRIMARY_IDLE_MODE);
  endfunction : idle_of

  // two-stage synchronisers for pin and oscillator inputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prim_d_r <= 1'b0;
      wake_d_r <= 1'b0;
    end else begin
      meta_r <= {wake_i, lf_ready_i, mf_ready_i, hf_ready_i, prim_osc_i};
      sync_r <= meta_r;
      prim_d_r <= sync_r[0];
      wake_d_r <= sync_r[4];
    end
  end

  assign prim_tick = sync_r[0] && !prim_d_r;
  assign wake_edge = sync_r[4] && !wake_d_r;

  // field views
  assign idle_bit = ctrl_r[IDLE_BIT];
  assign sel = ctrl_r[SEL_LSB +: 2];
  assign freq = ctrl_r[FREQ_LSB +: 3];
  assign primary_osc_config = cfg_r[PRIMARY_OSC_CONFIG_LSB +: 4];
  assign isel = int_osc_pick(freq, ctrl_r[SRC_BIT], ctrl_r[MID_BIT]);
  assign pin_cfg = primary_osc_config != INT_OSC;

  // bus handshake: one wait cycle, then the access completes
  assign req = avs_read_i || avs_write_i;
  assign commit_wr = avs_write_i && !wait_r;
  assign sleep_go = commit_wr && avs_address_i == CMD_OFS && avs_writedata_i[SLEEP_CMD_BIT];
  assign restart_go = commit_wr && avs_address_i == CMD_OFS && avs_writedata_i[RESTART_CMD_BIT];

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) wait_r <= 1'b1;
    else wait_r <= !(req && wait_r);
  end

  // read data captured in the wait cycle; unmapped and command read as zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) avs_readdata_o <= '0;
    else if (avs_read_i && wait_r) begin
      unique case (avs_address_i)
        CTRL_OFS: avs_readdata_o <= {24'h0, ctrl_r};
        CFG_OFS: avs_readdata_o <= {23'h0, cfg_r};
        STAT_OFS: avs_readdata_o <= {23'h0, status};
        default: avs_readdata_o <= '0;
      endcase
    end
  end

  // writable control and configuration; wake never touches them
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= CTRL_RST;
      cfg_r <= CFG_RST;
    end else if (commit_wr) begin
      if (avs_address_i == CTRL_OFS) ctrl_r <= avs_writedata_i[CTRL_W-1:0];
      if (avs_address_i == CFG_OFS) cfg_r <= avs_writedata_i[CFG_W-1:0];
    end
  end

  // start-up request after reset release or on software restart
  assign su.start_full = !started_r || restart_go;
  assign su.start_wake = wake_edge && mode_r inside {M_PRIMARY_IDLE_MODE, M_SECONDARY_IDLE_MODE, M_INT_IDLE, M_SLEEP};
  assign su.crystal = primary_osc_config <= HS_XTAL;
  assign su.pll_on = cfg_r[PLL_BIT] && primary_osc_config <= EXT_CLK;
  assign su.powerup_timer_on = !cfg_r[POWERUP_TIMER_ENABLE_N_N_BIT];
  assign su.hf_wait = primary_osc_config == INT_OSC && !cfg_r[FAST_BIT];
  assign su.prim_tick = prim_tick;
  assign su.hf_ready = sync_r[1];

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) started_r <= 1'b0;
    else started_r <= 1'b1;
  end

  // start-up phase stays open while any delay runs
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) startup_r <= 1'b0;
    else if (su.start_full) startup_r <= 1'b1;
    else if (!su.busy) startup_r <= 1'b0;
  end

  assign hold = startup_r || su.start_full;

  // power mode sequencing
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) mode_r <= M_PRIMARY_RUN_MODE;
    else begin
      unique case (mode_r)
        M_PRIMARY_RUN_MODE, M_SECONDARY_RUN_MODE, M_INT_RUN: begin
          if (sleep_go) mode_r <= idle_bit ? idle_of(sel) : M_SLEEP;
          else if (!su.busy) mode_r <= run_of(sel);
        end
        M_PRIMARY_IDLE_MODE, M_SECONDARY_IDLE_MODE, M_INT_IDLE, M_SLEEP: begin
          if (wake_edge) mode_r <= M_WAKE;
        end
        M_WAKE: begin
          if (!su.busy) mode_r <= run_of(sel);
        end
        default: mode_r <= M_PRIMARY_RUN_MODE;
      endcase
    end
  end

  // start-up complete flag: set on primary, kept through primary idle and wake
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) startup_complete_flag_r <= 1'b0;
    else if (mode_r inside {M_SECONDARY_RUN_MODE, M_SECONDARY_IDLE_MODE, M_INT_RUN, M_INT_IDLE, M_SLEEP}) startup_complete_flag_r <= 1'b0;
    else if (mode_r == M_PRIMARY_RUN_MODE && !su.busy) startup_complete_flag_r <= 1'b1;
  end

  // which source family the current mode uses
  assign prim_side = mode_r inside {M_PRIMARY_RUN_MODE, M_PRIMARY_IDLE_MODE} || (mode_r == M_WAKE && sel == SEL_PRIMARY);
  assign sec_side = mode_r inside {M_SECONDARY_RUN_MODE, M_SECONDARY_IDLE_MODE} || (mode_r == M_WAKE && sel == SEL_SECONDARY);
  assign int_act = mode_r inside {M_INT_RUN, M_INT_IDLE} || (mode_r == M_WAKE && sel[1]) || (prim_side && !pin_cfg);
  assign run_mode = mode_r inside {M_PRIMARY_RUN_MODE, M_SECONDARY_RUN_MODE, M_INT_RUN};

  // oscillator enables
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      primary_osc_en_o <= 1'b0;
      secondary_osc_en_o <= 1'b0;
      hf_osc_en_o <= 1'b0;
      mf_osc_en_o <= 1'b0;
      lf_osc_en_o <= 1'b0;
    end else begin
      primary_osc_en_o <= prim_side && pin_cfg;
      secondary_osc_en_o <= sec_side || (cfg_r[TMR_BIT] && mode_r != M_SLEEP);
      hf_osc_en_o <= int_act && isel == INT_HF;
      mf_osc_en_o <= int_act && isel == INT_MF;
      lf_osc_en_o <= (int_act && isel == INT_LF) || cfg_r[WDT_BIT];
    end
  end

  // system clock source and internal settings
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sys_clk_src_o <= SRC_PRIMARY;
      int_osc_sel_o <= INT_HF;
      int_freq_o <= '0;
    end else begin
      if (mode_r == M_SLEEP) sys_clk_src_o <= SRC_NONE;
      else if (prim_side) sys_clk_src_o <= pin_cfg ? SRC_PRIMARY : SRC_INTERNAL;
      else if (sec_side) sys_clk_src_o <= SRC_SECONDARY;
      else sys_clk_src_o <= SRC_INTERNAL;
      int_osc_sel_o <= isel;
      int_freq_o <= freq;
    end
  end

  // clock gating and reset hold
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      cpu_rst_b_o <= 1'b0;
      periph_rst_b_o <= 1'b0;
    end else begin
      cpu_clk_en_o <= !hold && run_mode && !su.busy;
      periph_clk_en_o <= !hold && mode_r != M_SLEEP;
      cpu_rst_b_o <= !hold;
      periph_rst_b_o <= !hold;
    end
  end

  // readable status, stable flags qualified by the enable
  assign status = {mode_r, su.busy,
                   (isel == INT_HF ? sync_r[1] && hf_osc_en_o :
                    isel == INT_MF ? sync_r[2] && mf_osc_en_o : sync_r[3] && lf_osc_en_o),
                   startup_complete_flag_r, sync_r[3] && lf_osc_en_o, sync_r[2] && mf_osc_en_o, sync_r[1] && hf_osc_en_o};

  assign avs_waitrequest_o = wait_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  primary_idle_mode_run_a: assert property (mode_r == M_PRIMARY_IDLE_MODE && pin_cfg |=> primary_osc_en_o)
    else $error("primary stopped in primary idle");
  pri_off_pm_a: assert property (mode_r inside {M_SECONDARY_RUN_MODE, M_SECONDARY_IDLE_MODE, M_INT_RUN, M_INT_IDLE, M_SLEEP}
      |=> !primary_osc_en_o)
    else $error("primary running in other mode");
  lf_excl_a: assert property (lf_osc_en_o && int_osc_sel_o == INT_LF |-> !hf_osc_en_o && !mf_osc_en_o)
    else $error("high or mid enabled with low direct");
  sleep_stop_a: assert property (mode_r == M_SLEEP
      |=> sys_clk_src_o == SRC_NONE && !hf_osc_en_o && !mf_osc_en_o && !secondary_osc_en_o)
    else $error("clock running in sleep");
  wdt_lf_a: assert property (cfg_r[WDT_BIT] |=> lf_osc_en_o)
    else $error("low-frequency stopped under watchdog");
  lf_pick_a: assert property (freq == 3'h0 && !ctrl_r[SRC_BIT] |=> int_osc_sel_o == INT_LF)
    else $error("wrong internal oscillator pick");
  startup_complete_flag_idle_a: assert property (mode_r == M_PRIMARY_IDLE_MODE |-> startup_complete_flag_r ##1 !cpu_clk_en_o)
    else $error("primary idle flag or cpu gate wrong");
  wake_delay_a: assert property (mode_r == M_PRIMARY_IDLE_MODE && wake_edge && !su.start_full
      |=> (mode_r == M_WAKE && !cpu_clk_en_o) [*8])
    else $error("cpu released before cpu-ready delay");
  hold_rst_a: assert property (startup_r && su.busy |=> !cpu_rst_b_o && !cpu_clk_en_o && !periph_clk_en_o)
    else $error("reset released during delays");

  sleep_c: cover property (mode_r == M_SLEEP ##1 mode_r == M_WAKE);
  pri_wake_c: cover property (mode_r == M_PRIMARY_IDLE_MODE ##1 mode_r == M_WAKE);
  startup_done_c: cover property ($rose(cpu_rst_b_o));
endmodule : clock_mode_ctrl
`default_nettype wire

// ---- testbench/osc_model.sv ----
// far-side oscillators: primary clock pin and internal ready levels
// assumes enables from the clock controller on the same core clock
`timescale 1ns/1ps
`default_nettype none
module osc_model (
  input wire logic core_clk_i, // core clock
  input wire logic prim_en_i, // primary enable
  input wire logic hf_en_i, // high-frequency enable
  input wire logic mf_en_i, // mid-frequency enable
  input wire logic lf_en_i, // low-frequency enable
  output logic prim_osc_o, // primary pin, rests low when stopped
  output logic hf_ready_o, // high-frequency stable
  output logic mf_ready_o, // mid-frequency stable
  output logic lf_ready_o // low-frequency stable
);
  logic [2:0] div_r = 3'h0;
  logic [3:0] hf_r = 4'h0, mf_r = 4'h0, lf_r = 4'h0;
  // primary pin runs at one eighth of the core clock while enabled
  always @(posedge core_clk_i) div_r <= (prim_en_i === 1'b1) ? div_r + 3'h1 : 3'h0;
  assign prim_osc_o = div_r[2];
  // each internal oscillator turns stable eight cycles after its enable, drops at once when disabled
  always @(posedge core_clk_i) begin
    hf_r <= (hf_en_i === 1'b1) ? hf_r + {3'h0, ~hf_r[3]} : 4'h0;
    mf_r <= (mf_en_i === 1'b1) ? mf_r + {3'h0, ~mf_r[3]} : 4'h0;
    lf_r <= (lf_en_i === 1'b1) ? lf_r + {3'h0, ~lf_r[3]} : 4'h0;
  end
  assign hf_ready_o = hf_r[3];
  assign mf_ready_o = mf_r[3];
  assign lf_ready_o = lf_r[3];
endmodule : osc_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the power-mode clock controller: register tasks and mode scenarios
// assumes the oscillator model at the far side and a 20 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import clk_ctrl_pkg::*;
  logic core_clk_i, rst_b_i, avs_read_i, avs_write_i, prim_osc_i, hf_ready_i, mf_ready_i, lf_ready_i, wake_i;
  logic [3:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rv, m;
  logic avs_waitrequest_o, primary_osc_en_o, secondary_osc_en_o, hf_osc_en_o, mf_osc_en_o, lf_osc_en_o;
  logic cpu_clk_en_o, periph_clk_en_o, cpu_rst_b_o, periph_rst_b_o;
  logic [2:0] int_freq_o;
  clk_src_t sys_clk_src_o;
  int_osc_t int_osc_sel_o, e;
  int n_fail, num_checks, n;

  // controller with a short pll lock wait
  clock_mode_ctrl #(.PLL_CYC(50)) i_clock_mode_ctrl (.core_clk_i, .rst_b_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .prim_osc_i, .hf_ready_i, .mf_ready_i,
    .lf_ready_i, .wake_i, .primary_osc_en_o, .secondary_osc_en_o, .hf_osc_en_o, .mf_osc_en_o, .lf_osc_en_o,
    .sys_clk_src_o, .int_osc_sel_o, .int_freq_o, .cpu_clk_en_o, .periph_clk_en_o, .cpu_rst_b_o, .periph_rst_b_o);
  osc_model i_osc_model (.core_clk_i, .prim_en_i(primary_osc_en_o), .hf_en_i(hf_osc_en_o), .mf_en_i(mf_osc_en_o),
    .lf_en_i(lf_osc_en_o), .prim_osc_o(prim_osc_i), .hf_ready_o(hf_ready_i), .mf_ready_o(mf_ready_i),
    .lf_ready_o(lf_ready_i));

  // 50 ns core clock
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // value compare, mismatch reported at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // measured delay compare against a window of cycles
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  // one avalon transfer, request held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge core_clk_i);
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge core_clk_i);
      t++;
    end while (avs_waitrequest_o !== 1'b0 && t < 50);
    rv = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    chk("waitrequest", 0, avs_waitrequest_o);
  endtask : xfer

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr_reg

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] mk, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rv & mk);
  endtask : rd_chk

  // count cycles until the cpu reset lifts or the cpu clock returns
  task automatic meas(input bit on_clk);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while ((on_clk ? cpu_clk_en_o : cpu_rst_b_o) !== 1'b1 && n < 20000);
  endtask : meas

  // rerun every delay with a new configuration
  task automatic rerun(input logic [31:0] c);
    wr_reg(CFG_OFS, c);
    wr_reg(CMD_OFS, 32'h2);
    repeat (3) @(posedge core_clk_i);
    chk("reset held", 0, cpu_rst_b_o);
    chk("periph reset held", 0, periph_rst_b_o);
    meas(1'b0);
  endtask : rerun

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // hang guard
  initial begin
    repeat (60000) @(posedge core_clk_i);
    n_fail++;
    wrap_up;
  end

  initial begin
    rst_b_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    wake_i = 1'b0;
    n_fail = 0;
    num_checks = 0;
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    // reset values, then power-up from the default high-speed crystal
    rd_chk("ctrl", CTRL_OFS, 32'hffffffff, 32'h18);
    rd_chk("cfg", CFG_OFS, 32'hffffffff, 32'h2);
    rd_chk("cmd", CMD_OFS, 32'hffffffff, 32'h0);
    chk("cpu reset", 0, cpu_rst_b_o);
    meas(1'b0);
    chk_rng("crystal start", 8100, 8320, n);
    rd_chk("status", STAT_OFS, 32'h1e8, 32'h8);
    // delay combinations by configuration
    rerun(32'h13);
    chk_rng("cpu-ready only", 34, 46, n);
    rerun(32'h03);
    chk_rng("power-up timer", 1274, 1290, n);
    rerun(32'h52);
    chk_rng("start-up and pll", 8180, 8320, n);
    rerun(32'h93);
    chk_rng("no power-up timer", 34, 46, n);
    // every frequency field, source and mid-select combination in internal run
    for (int i = 0; i < 32; i++) begin
      wr_reg(CTRL_OFS, {24'h0, i[4:0], 3'h4});
      if (i[2:0] == 3'h0 && !i[3]) e = INT_LF;
      else if (i[2:0] <= 3'h2) e = i[4] ? INT_MF : INT_HF;
      else e = INT_HF;
      m = 32'h10 | (32'h1 << (2 - int'(e)));
      repeat (16) @(posedge core_clk_i);
      chk("internal pick", {30'h0, e}, {30'h0, int_osc_sel_o});
      chk("internal source", {30'h0, SRC_INTERNAL}, {30'h0, sys_clk_src_o});
      chk("postscaler", {29'h0, i[2:0]}, {29'h0, int_freq_o});
      chk("primary off", 0, primary_osc_en_o);
      if (e == INT_LF) chk("high and mid off", 0, {hf_osc_en_o, mf_osc_en_o});
      rd_chk("stable flag", STAT_OFS, m, m);
    end
    // secondary run, then primary idle entered via primary run
    wr_reg(CTRL_OFS, 32'h1a);
    repeat (4) @(posedge core_clk_i);
    chk("secondary source", {30'h0, SRC_SECONDARY}, {30'h0, sys_clk_src_o});
    chk("secondary on primary off", 32'h2, {secondary_osc_en_o, primary_osc_en_o});
    rd_chk("secondary mode", STAT_OFS, 32'h1c8, 32'h40);
    wr_reg(CTRL_OFS, 32'h1b);
    wr_reg(CTRL_OFS, 32'h19);
    wr_reg(CMD_OFS, 32'h1);
    repeat (4) @(posedge core_clk_i);
    chk("idle gates", 32'h5, {primary_osc_en_o, cpu_clk_en_o, periph_clk_en_o});
    rd_chk("idle status", STAT_OFS, 32'h1c8, 32'hc8);
    wake_i <= 1'b1;
    meas(1'b1);
    wake_i <= 1'b0;
    chk_rng("idle wake", 40, 50, n);
    rd_chk("ctrl kept", CTRL_OFS, 32'hff, 32'h19);
    rd_chk("run status", STAT_OFS, 32'h1c8, 32'h8);
    // sleep with the watchdog needing the low-frequency oscillator
    wr_reg(CTRL_OFS, 32'h18);
    wr_reg(CMD_OFS, 32'h1);
    repeat (4) @(posedge core_clk_i);
    chk("sleep off", 0, {primary_osc_en_o, secondary_osc_en_o, hf_osc_en_o, mf_osc_en_o, cpu_clk_en_o});
    chk("watchdog osc", 1, lf_osc_en_o);
    chk("no source", {30'h0, SRC_NONE}, {30'h0, sys_clk_src_o});
    rd_chk("sleep mode", STAT_OFS, 32'h1c0, 32'h180);
    wake_i <= 1'b1;
    meas(1'b1);
    wake_i <= 1'b0;
    chk_rng("sleep wake", 40, 50, n);
    // timers needing the secondary oscillator keep it running in primary run
    wr_reg(CFG_OFS, 32'h193);
    repeat (3) @(posedge core_clk_i);
    chk("timer secondary", 1, secondary_osc_en_o);
    chk("primary kept", 1, primary_osc_en_o);
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
